/* bbp_pkg.sv */
// shared constants and types for the bit-bang parallel port
package bbp_pkg;
    localparam int          BBP_WIDTH      = 8;          // port pins
    localparam int          BBP_FIFO_DEPTH = 8;          // words in buffer
    localparam logic [7:0]  BBP_MODE_OFF   = 8'h00;      // port released
    localparam logic [7:0]  BBP_MODE_ASYNC = 8'h01;      // baud paced
    localparam logic [7:0]  BBP_MODE_SYNC  = 8'h04;      // one in, one out
    localparam logic [7:0]  BBP_DIR_RST    = 8'h00;      // all inputs
    localparam logic [7:0]  BBP_BYTE_RST   = 8'h00;      // data after reset
    localparam logic        BBP_STB_IDLE   = 1'b1;       // strobes inactive
    localparam int          BBP_CLK_KHZ    = 200000;     // ref_clk rate
    localparam int          BBP_WAKE_MS    = 20;         // wake pulse, ms
    localparam int          BBP_WAKE_CYC   = BBP_WAKE_MS * BBP_CLK_KHZ;
    localparam int          BBP_BAUD_DIV   = 16;         // cycles per tick
    localparam int          BBP_FLUSH_CYC  = 4;          // flush pulse width
    localparam logic [31:0] BBP_CNT_RST    = 32'h0000_0000;

    // per-byte sequencer of the device end
    typedef enum logic [2:0] {
        BBP_IDLE   = 3'b000,   // wait for byte and room
        BBP_SAMPLE = 3'b001,   // read pin state
        BBP_SEND   = 3'b010,   // sample strobe up, sample to host
        BBP_UPDATE = 3'b011,   // sample strobe down, new outputs
        BBP_SETUP  = 3'b100,   // one cycle of data setup
        BBP_WSTB   = 3'b101,   // update strobe active
        BBP_WEND   = 3'b110    // update strobe inactive
    } bbp_state_t;

    // three-stage filter: a bit changes once stages two and three agree
    function automatic logic [7:0] bbp_filt(input logic [7:0] s2,
                                            input logic [7:0] s3,
                                            input logic [7:0] f);
        return (s2 & s3) | (f & (s2 ^ s3));
    endfunction
endpackage

/* bbp_link_if.sv */
// pins and strobes between the port device and the external logic
`timescale 1ns/1ps
interface bbp_link_if;
    import bbp_pkg::*;
    logic [7:0] dev_pin_o;            // device pin data
    logic [7:0] dev_pin_oe;           // device drives pin when high
    logic [7:0] ext_pin_o;            // external pin data
    logic [7:0] ext_pin_oe;           // external drives pin when high
    logic [7:0] pins;                 // resolved pin level
    logic       pin_sample_strobe_n;  // device read strobe
    logic       pin_update_strobe_n;  // device write strobe
    logic       flush_or_wake_n;      // external send-immediate / wake

    // undriven pins float high through the pull-ups
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dev_pin_oe[i])
                pins[i] = dev_pin_o[i];
            else if (ext_pin_oe[i])
                pins[i] = ext_pin_o[i];
            else
                pins[i] = 1'b1;
        end
    end

    modport dev (output dev_pin_o, dev_pin_oe, pin_sample_strobe_n,
                 pin_update_strobe_n, input pins, flush_or_wake_n);
    modport ext (output ext_pin_o, ext_pin_oe, flush_or_wake_n,
                 input pins, pin_sample_strobe_n, pin_update_strobe_n);
endinterface

/* bbp_device.sv */
// device end: host-to-port buffer and the bit-bang port sequencer
// Contract
// - async mode drives written bytes, baud paced
// - async outputs change on new byte plus tick
// - each pin input or output by mask
// - async mode presents read and write strobes
// - sync outputs change only on host byte
// - sync write strobe after byte driven out
// - sync returns one sample per written byte
// - sync takes byte only with return room
// - sync samples pins before driving new byte
// - mode code 1 selects async mode
// - mode code 4 selects sync mode
// - sample, strobe up, update, setup, write pulse
// - read strobe rise marks sample captured
// - setup mask holds direction until next setup
// - all-input port still needs written bytes
// - flush input falling edge flushes host data
// - external logic flushes only after sending stops
// - 20ms low pulse requests remote wake
// - pull-down enabled blocks wake from suspend
`timescale 1ns/1ps
module bbp_fifo
    import bbp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,   // clock
    input  wire logic             nrst,      // async reset, active low
    input  wire logic [WIDTH-1:0] in_data,   // filling side data
    input  wire logic             in_valid,  // filling side offer
    output logic                  in_ready,  // room for a word
    output logic      [WIDTH-1:0] out_data,  // oldest word
    output logic                  out_valid, // a word is held
    input  wire logic             out_ready  // draining side takes it
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] LAST = (AW+1)'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage
        logic [AW:0]                 wp;    // write index
        logic [AW:0]                 rp;    // read index
        logic [AW:0]                 cnt;   // words held
    } bbp_fifo_st_t;

    bbp_fifo_st_t s_q;  // registered state
    bbp_fifo_st_t s_d;  // next state
    logic         push; // word enters
    logic         pop;  // word leaves

    // honest full and empty straight from the count
    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rp[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp[AW-1:0]] = in_data;
            s_d.wp = (s_q.wp == LAST) ? '0 : s_q.wp + 1'b1;
        end
        if (pop)
            s_d.rp = (s_q.rp == LAST) ? '0 : s_q.rp + 1'b1;
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule

module bbp_device
    import bbp_pkg::*;
#(
    parameter int WAKE_CYC = BBP_WAKE_CYC,  // wake low time in cycles
    parameter int BAUD_DIV = BBP_BAUD_DIV   // cycles per baud tick
) (
    input  wire logic       ref_clk,       // 200 MHz clock
    input  wire logic       nrst,          // async reset, active low
    bbp_link_if.dev         link,          // pins and strobes
    input  wire logic       cmd_valid,     // mode-select command pulse
    input  wire logic [7:0] cmd_mode,      // mode code
    input  wire logic [7:0] cmd_mask,      // direction mask, 1 = output
    input  wire logic [7:0] h2p_data,      // byte from host
    input  wire logic       h2p_valid,     // host offers byte
    output logic            h2p_ready,     // buffer has room
    output logic      [7:0] p2h_data,      // sampled byte to host
    output logic            p2h_valid,     // sample waiting
    input  wire logic       p2h_ready,     // host takes sample
    output logic            flush_pulse,   // send buffered data now
    input  wire logic       suspended,     // bus is suspended
    input  wire logic       wake_pd_en,    // pull-down on wake input
    output logic            wake_pulse,    // signal remote wake-up
    output logic      [7:0] cur_mode       // active mode code
);
    typedef struct packed {
        logic [7:0]  mode;   // active mode code
        logic [7:0]  dir;    // direction mask
        bbp_state_t  st;     // sync sequencer
        logic [7:0]  ps1;    // pin sync stage 1
        logic [7:0]  ps2;    // pin sync stage 2
        logic [7:0]  ps3;    // pin sync stage 3
        logic [7:0]  pf;     // filtered pins
        logic [2:0]  fs;     // flush input sync stages
        logic        ff;     // filtered flush level
        logic [7:0]  out;    // driven byte
        logic        rd_n;   // sample strobe
        logic        wr_n;   // update strobe
        logic [7:0]  smp;    // sample for host
        logic        smp_v;  // sample waiting
        logic [31:0] baud;   // baud divider
        logic [31:0] wcnt;   // wake low time
        logic        flush;  // flush pulse
        logic        wake;   // wake pulse
    } bbp_dev_st_t;

    bbp_dev_st_t s_q;       // registered state
    bbp_dev_st_t s_d;       // next state
    logic [7:0]  buf_data;  // buffer head
    logic        buf_valid; // buffer not empty
    logic        buf_pop;   // take head
    logic        tick;      // baud tick
    logic        is_async;  // mode 1 active
    logic        is_sync;   // mode 4 active
    logic        fw_level;  // filtered flush level, next value

    // host bytes queue here; back-pressure reaches host through ready
    bbp_fifo #(.WIDTH(BBP_WIDTH), .DEPTH(BBP_FIFO_DEPTH)) bbp_fifo_inst (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_data   (h2p_data),
        .in_valid  (h2p_valid),
        .in_ready  (h2p_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop)
    );

    assign is_async = (s_q.mode == BBP_MODE_ASYNC);
    assign is_sync  = (s_q.mode == BBP_MODE_SYNC);
    assign tick     = (s_q.baud == 32'(BAUD_DIV - 1));
    assign fw_level = s_q.fs[1] ? (s_q.fs[2] | s_q.ff)
                                : (s_q.fs[2] & s_q.ff);

    // pop only where the sequencer drives the head onto the pins
    always_comb begin
        buf_pop = 1'b0;
        if (is_sync && s_q.st == BBP_UPDATE)
            buf_pop = 1'b1;
        else if (is_async && tick && buf_valid)
            buf_pop = 1'b1;
    end

    // next-state logic for the whole port
    always_comb begin
        s_d       = s_q;
        s_d.flush = 1'b0;
        s_d.wake  = 1'b0;
        // pins and flush input: three flops, stages two and three agree
        s_d.ps1 = link.pins;
        s_d.ps2 = s_q.ps1;
        s_d.ps3 = s_q.ps2;
        s_d.pf  = bbp_filt(s_q.ps2, s_q.ps3, s_q.pf);
        s_d.fs  = {s_q.fs[1:0], link.flush_or_wake_n};
        s_d.ff  = fw_level;
        // falling edge of the filtered level asks for a flush
        if (s_q.ff && !fw_level)
            s_d.flush = 1'b1;
        // wake: held low long enough, unless pull-down blocks it
        if (fw_level)
            s_d.wcnt = BBP_CNT_RST;
        else if (s_q.wcnt != 32'(WAKE_CYC))
            s_d.wcnt = s_q.wcnt + 32'd1;
        if (s_q.wcnt == 32'(WAKE_CYC - 1) && !fw_level &&
            suspended && !wake_pd_en)
            s_d.wake = 1'b1;
        // host takes the pending sample
        if (s_q.smp_v && p2h_ready)
            s_d.smp_v = 1'b0;
        // baud generator free runs only in async mode
        s_d.baud = (is_async && !tick) ? s_q.baud + 32'd1 : BBP_CNT_RST;
        if (is_async) begin
            // read strobe pulse low, sample captured on its rise
            if (!s_q.rd_n) begin
                s_d.rd_n = 1'b1;
                s_d.smp  = s_q.pf;
                s_d.smp_v = 1'b1;
            end else if (tick && !s_q.smp_v) begin
                s_d.rd_n = 1'b0;
            end
            // write strobe pulse with each baud-paced update
            if (!s_q.wr_n)
                s_d.wr_n = 1'b1;
            if (tick && buf_valid) begin
                s_d.out  = buf_data;
                s_d.wr_n = 1'b0;
            end
        end else if (is_sync) begin
            unique case (s_q.st)
                BBP_IDLE: begin
                    // need both a byte and room for its sample
                    if (buf_valid && !s_q.smp_v)
                        s_d.st = BBP_SAMPLE;
                end
                BBP_SAMPLE: begin
                    s_d.smp = s_q.pf;
                    s_d.st  = BBP_SEND;
                end
                BBP_SEND: begin
                    s_d.rd_n  = 1'b1;
                    s_d.smp_v = 1'b1;
                    s_d.st    = BBP_UPDATE;
                end
                BBP_UPDATE: begin
                    s_d.rd_n = 1'b0;
                    s_d.out  = buf_data;
                    s_d.st   = BBP_SETUP;
                end
                BBP_SETUP: begin
                    s_d.st = BBP_WSTB;
                end
                BBP_WSTB: begin
                    s_d.wr_n = 1'b0;
                    s_d.st   = BBP_WEND;
                end
                BBP_WEND: begin
                    s_d.wr_n = 1'b1;
                    s_d.st   = BBP_IDLE;
                end
                default: s_d.st = BBP_IDLE;               // illegal code
            endcase
        end
        // a command aborts any sequence; sync idles with read strobe low
        if (cmd_valid) begin
            s_d.mode = cmd_mode;
            s_d.dir  = cmd_mask;
            s_d.st   = BBP_IDLE;
            s_d.wr_n = BBP_STB_IDLE;
            s_d.rd_n = (cmd_mode == BBP_MODE_SYNC) ? 1'b0 : BBP_STB_IDLE;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q      <= '0;
            s_q.mode <= BBP_MODE_OFF;
            s_q.dir  <= BBP_DIR_RST;
            s_q.st   <= BBP_IDLE;
            s_q.fs   <= 3'h7;
            s_q.ff   <= 1'b1;
            s_q.rd_n <= BBP_STB_IDLE;
            s_q.wr_n <= BBP_STB_IDLE;
            s_q.ps1  <= 8'hFF;
            s_q.ps2  <= 8'hFF;
            s_q.ps3  <= 8'hFF;
            s_q.pf   <= 8'hFF;
        end else begin
            s_q <= s_d;
        end
    end

    // only output pins are driven; the port is released when off
    assign link.dev_pin_o  = s_q.out;
    assign link.dev_pin_oe = (is_async || is_sync) ? s_q.dir
                                                   : 8'h00;
    assign link.pin_sample_strobe_n = s_q.rd_n;
    assign link.pin_update_strobe_n = s_q.wr_n;
    assign p2h_data    = s_q.smp;
    assign p2h_valid   = s_q.smp_v;
    assign flush_pulse = s_q.flush;
    assign wake_pulse  = s_q.wake;
    assign cur_mode    = s_q.mode;
endmodule

/* bbp_extern.sv */
// external logic end: pin drive, strobe capture, flush and wake pulses
`timescale 1ns/1ps
module bbp_extern
    import bbp_pkg::*;
#(
    parameter int WAKE_CYC  = BBP_WAKE_CYC,  // wake pulse width, cycles
    parameter int FLUSH_CYC = BBP_FLUSH_CYC  // flush pulse width, cycles
) (
    input  wire logic       ref_clk,     // 200 MHz clock
    input  wire logic       nrst,        // async reset, active low
    bbp_link_if.ext         link,        // pins and strobes
    input  wire logic [7:0] drv_data,    // byte to drive
    input  wire logic [7:0] drv_en,      // pins to drive
    input  wire logic       sending,     // user still feeding data
    input  wire logic       flush_req,   // request a flush pulse
    input  wire logic       wake_req,    // request a wake pulse
    output logic      [7:0] upd_data,    // pins at update strobe
    output logic            upd_pulse,   // update strobe seen
    output logic            smp_pulse,   // sample strobe rise seen
    output logic            fw_busy      // flush or wake pulse running
);
    typedef struct packed {
        logic [1:0]  sf;    // strobes one cycle ago {update, sample}
        logic [7:0]  dat;   // captured byte
        logic        upd;   // update pulse
        logic        smp;   // sample pulse
        logic [7:0]  o;     // driven data
        logic [7:0]  oe;    // driven enables
        logic        low;   // flush or wake low
        logic [31:0] cnt;   // low time left
    } bbp_ext_st_t;

    bbp_ext_st_t s_q;  // registered state
    bbp_ext_st_t s_d;  // next state
    logic [1:0]  sfn;  // strobes now {update, sample}

    // both ends run on ref_clk, so strobes and pins are read directly;
    // a one-cycle strobe would never pass an agreement filter
    assign sfn = {link.pin_update_strobe_n, link.pin_sample_strobe_n};

    // next-state logic
    always_comb begin
        s_d     = s_q;
        s_d.upd = 1'b0;
        s_d.smp = 1'b0;
        s_d.sf  = sfn;
        s_d.o   = drv_data;
        s_d.oe  = drv_en;
        // update strobe falling: pins carry the new byte
        if (s_q.sf[1] && !sfn[1]) begin
            s_d.dat = link.pins;
            s_d.upd = 1'b1;
        end
        // sample strobe rising: device has taken its sample
        if (!s_q.sf[0] && sfn[0])
            s_d.smp = 1'b1;
        // low pulse timer; a flush request made while feeding continues is dropped
        if (s_q.low) begin
            if (s_q.cnt == 32'd1)
                s_d.low = 1'b0;
            s_d.cnt = s_q.cnt - 32'd1;
        end else if (wake_req) begin
            s_d.low = 1'b1;
            s_d.cnt = 32'(WAKE_CYC);
        end else if (flush_req && !sending) begin
            s_d.low = 1'b1;
            s_d.cnt = 32'(FLUSH_CYC);
        end
    end

    // state register; lines idle high
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q     <= '0;
            s_q.sf  <= 2'h3;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.ext_pin_o      = s_q.o;
    assign link.ext_pin_oe     = s_q.oe;
    assign link.flush_or_wake_n = !s_q.low;
    assign upd_data  = s_q.dat;
    assign upd_pulse = s_q.upd;
    assign smp_pulse = s_q.smp;
    assign fw_busy   = s_q.low;
endmodule

/* bbp_link_checker.sv */
// concurrent checks on the link between device and external logic
`timescale 1ns/1ps
module bbp_link_checker (
    input wire logic       ref_clk,             // clock
    input wire logic       nrst,                // async reset, active low
    input wire logic [7:0] dev_pin_o,           // device pin data
    input wire logic [7:0] dev_pin_oe,          // device pin enables
    input wire logic       pin_sample_strobe_n, // read strobe
    input wire logic       pin_update_strobe_n, // write strobe
    input wire logic       flush_or_wake_n      // flush or wake line
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // lines idle and pins released as reset lets go
    a_reset_idle_lines: assert property ($rose(nrst) |->
        pin_sample_strobe_n && pin_update_strobe_n && flush_or_wake_n
        && dev_pin_oe == 8'h00) else $error("lines not idle after reset");
    // write strobe is a single low cycle
    a_update_one_cycle: assert property (
        $fell(pin_update_strobe_n) |=> pin_update_strobe_n)
        else $error("write strobe longer than one cycle");
    // write strobe pulses never merge: at least two idle cycles between pulses
    a_update_gap_kept: assert property (
        $rose(pin_update_strobe_n) |=> pin_update_strobe_n)
        else $error("write strobe pulses merged");
    // data holds across the strobe so external logic sees it settled
    a_data_held_strobe: assert property (
        $fell(pin_update_strobe_n) |=> $stable(dev_pin_o))
        else $error("pin data moved under write strobe");
    // driven pins change only as part of a strobed write
    a_write_needs_strobe: assert property (
        $changed(dev_pin_o) && dev_pin_oe != 8'h00
        |-> ##[0:2] $fell(pin_update_strobe_n))
        else $error("pins changed without write strobe");
    // sync order: read strobe rise, drop, one setup cycle, write pulse
    a_sync_write_order: assert property (
        $rose(pin_sample_strobe_n) ##1 $fell(pin_sample_strobe_n)
        |=> pin_update_strobe_n ##1 !pin_update_strobe_n)
        else $error("sync write strobe out of order");
    // flush or wake low time has a floor
    a_fw_low_floor: assert property (
        $fell(flush_or_wake_n) |-> !flush_or_wake_n [*4])
        else $error("flush or wake pulse too short");
    // and a ceiling, the wake width
    a_fw_low_ceiling: assert property (
        $fell(flush_or_wake_n) |-> ##[4:50] flush_or_wake_n)
        else $error("flush or wake pulse too long");

    // main scenarios reached
    c_sync_byte: cover property ($rose(pin_sample_strobe_n));
    c_write: cover property ($fell(pin_update_strobe_n));
    c_flush: cover property ($fell(flush_or_wake_n));
endmodule

/* bbp_bench.sv */
// self-checking bench: device and external logic joined by the link
`timescale 1ns/1ps
module bbp_bench;
    import bbp_pkg::*;
    logic       ref_clk    = 1'b0;  // 200 MHz clock
    logic       nrst       = 1'b0;  // reset, active low
    logic       cmd_valid  = 1'b0;  // mode command
    logic [7:0] cmd_mode   = 8'h00; // mode code
    logic [7:0] cmd_mask   = 8'h00; // direction mask
    logic [7:0] h2p_data   = 8'h00; // host byte
    logic       h2p_valid  = 1'b0;  // host offers byte
    logic       p2h_ready  = 1'b0;  // host takes sample
    logic       suspended  = 1'b0;  // bus suspended
    logic       wake_pd_en = 1'b0;  // wake pull-down
    logic [7:0] drv_data   = 8'h00; // external pin data
    logic [7:0] drv_en     = 8'h00; // external pin enables
    logic       sending    = 1'b1;  // external still feeding
    logic       flush_req  = 1'b0;  // flush request
    logic       wake_req   = 1'b0;  // wake request
    logic       h2p_ready, p2h_valid, flush_pulse, wake_pulse;
    logic       upd_pulse, smp_pulse;
    logic [7:0] p2h_data, cur_mode, upd_data;
    logic [7:0] n_upd = 8'h00, n_smp = 8'h00; // strobe counts
    logic [7:0] n_fl = 8'h00, n_wk = 8'h00;   // flush, wake counts
    int         fail_count = 0;
    int         checks_done = 0;

    bbp_link_if link();
    // short wake width keeps the run brief
    bbp_device #(.WAKE_CYC(50), .BAUD_DIV(4)) bbp_device_inst (
        .ref_clk(ref_clk), .nrst(nrst), .link(link.dev),
        .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .cmd_mask(cmd_mask),
        .h2p_data(h2p_data), .h2p_valid(h2p_valid), .h2p_ready(h2p_ready),
        .p2h_data(p2h_data), .p2h_valid(p2h_valid), .p2h_ready(p2h_ready),
        .flush_pulse(flush_pulse), .suspended(suspended),
        .wake_pd_en(wake_pd_en), .wake_pulse(wake_pulse),
        .cur_mode(cur_mode));
    bbp_extern #(.WAKE_CYC(50)) bbp_extern_inst (
        .ref_clk(ref_clk), .nrst(nrst), .link(link.ext),
        .drv_data(drv_data), .drv_en(drv_en), .sending(sending),
        .flush_req(flush_req), .wake_req(wake_req), .upd_data(upd_data),
        .upd_pulse(upd_pulse), .smp_pulse(smp_pulse), .fw_busy());
    bbp_link_checker bbp_link_checker_inst (
        .ref_clk(ref_clk), .nrst(nrst), .dev_pin_o(link.dev_pin_o),
        .dev_pin_oe(link.dev_pin_oe),
        .pin_sample_strobe_n(link.pin_sample_strobe_n),
        .pin_update_strobe_n(link.pin_update_strobe_n),
        .flush_or_wake_n(link.flush_or_wake_n));

    // clock
    initial forever #2.5 ref_clk = ~ref_clk;

    // pulse counters
    always @(posedge ref_clk) begin
        if (upd_pulse) n_upd <= n_upd + 8'h01;
        if (smp_pulse) n_smp <= n_smp + 8'h01;
        if (flush_pulse) n_fl <= n_fl + 8'h01;
        if (wake_pulse) n_wk <= n_wk + 8'h01;
    end

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // mode command, then time for pins to pass the input filter
    task automatic cmd(input logic [7:0] mode, input logic [7:0] mask);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_mode  <= mode;
        cmd_mask  <= mask;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    // host byte, held until ready is seen at an edge
    task automatic put(input logic [7:0] b);
        @(posedge ref_clk);
        h2p_data  <= b;
        h2p_valid <= 1'b1;
        @(negedge ref_clk);
        while (h2p_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        h2p_valid <= 1'b0;
    endtask
    // wait a bounded time for a sample, compare, take it
    task automatic get(input logic [7:0] exp);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (p2h_valid !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk("sample valid", {7'h00, p2h_valid}, 8'h01);
        chk("sample", p2h_data, exp);
        @(posedge ref_clk);
        p2h_ready <= 1'b1;
        @(posedge ref_clk);
        p2h_ready <= 1'b0;
    endtask
    // one flush or wake request from the external side
    task automatic req(input logic wake);
        @(posedge ref_clk);
        flush_req <= ~wake;
        wake_req  <= wake;
        @(posedge ref_clk);
        flush_req <= 1'b0;
        wake_req  <= 1'b0;
        repeat (80) @(posedge ref_clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, far beyond the several hundred cycles needed
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        // sync: three bytes queued, only one runs while sample unread
        cmd(BBP_MODE_SYNC, 8'hFF);
        chk("mode", cur_mode, 8'h04);
        put(8'h55);
        put(8'hAA);
        put(8'hAA);
        repeat (40) @(posedge ref_clk);
        chk("stalled writes", n_upd, 8'h01);
        // outputs enabled by the command show the byte held since reset
        get(BBP_BYTE_RST);
        get(8'h55);
        get(8'hAA);
        repeat (20) @(posedge ref_clk);
        chk("writes", n_upd, 8'h03);
        chk("samples", n_smp, 8'h03);
        chk("pins", link.pins, 8'hAA);
        chk("strobed data", upd_data, 8'hAA);
        $display("test sync done");
        // upper nibble external, then all inputs
        drv_en   <= 8'hF0;
        drv_data <= 8'hA0;
        cmd(BBP_MODE_SYNC, 8'h0F);
        put(8'h3C);
        get(8'hAA);
        put(8'h00);
        get(8'hAC);
        chk("mask", link.dev_pin_oe, 8'h0F);
        cmd(BBP_MODE_SYNC, 8'h00);
        put(8'hFF);
        get(8'hAF);
        $display("test direction done");
        // fill while off until refused, drain in async mode
        cmd(BBP_MODE_OFF, 8'h00);
        for (int i = 0; i < 8; i++) begin
            put(8'h10 + 8'(i));
        end
        @(negedge ref_clk);
        chk("full", {7'h00, h2p_ready}, 8'h00);
        cmd(BBP_MODE_ASYNC, 8'hFF);
        repeat (60) @(posedge ref_clk);
        chk("mode", cur_mode, 8'h01);
        chk("drained", {7'h00, h2p_ready}, 8'h01);
        chk("async pins", link.pins, 8'h17);
        chk("async writes", n_upd, 8'h0E);
        put(8'h5A);
        repeat (30) @(posedge ref_clk);
        chk("async pins", link.pins, 8'h5A);
        chk("async writes", n_upd, 8'h0F);
        // leaving sync mode lifts the idle-low sample strobe once
        chk("async samples", n_smp, 8'h08);
        $display("test async done");
        // flush refused while sending, then flush, then wake
        req(1'b0);
        chk("flush sending", n_fl, 8'h00);
        sending <= 1'b0;
        req(1'b0);
        chk("flush", n_fl, 8'h01);
        chk("no wake", n_wk, 8'h00);
        suspended  <= 1'b1;
        wake_pd_en <= 1'b1;
        req(1'b1);
        chk("wake blocked", n_wk, 8'h00);
        wake_pd_en <= 1'b0;
        req(1'b1);
        chk("wake", n_wk, 8'h01);
        $display("test flush wake done");
        conclude();
    end
endmodule
